// file: verilog/mdt_pkg.sv
/*
 * Shared constants and types of the magstripe clock/data transmitter:
 * bit timing, digit codes, setting field positions, state encodings.
 * Assumes a 200 MHz core clock.
 */
package mdt_pkg;

	localparam int          CLK_PERIOD_NS = 5;
	localparam int          PHASE_TIME_NS = 330000;
	// One third of the default bit cell, rounded up to whole cycles
	localparam int          PHASE_CYCLES  = (PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TIMER_W       = 17;

	localparam logic [4:0]  RUN_BITS      = 5'h10;
	localparam logic [4:0]  DIGIT_BITS    = 5'h05;

	localparam logic [3:0]  DIG_START     = 4'hb;
	localparam logic [3:0]  DIG_STOP      = 4'hf;
	localparam logic [3:0]  DIG_SEP       = 4'hd;
	localparam logic [3:0]  DIG_MAX_DEC   = 4'h9;
	localparam logic [3:0]  DIG_TEN       = 4'ha;

	localparam int          SET_RAW_BIT   = 7;
	localparam int          SET_TRANS_LSB = 2;

	localparam logic [1:0]  TR_DROP       = 2'h0;
	localparam logic [1:0]  TR_SEP        = 2'h1;
	localparam logic [1:0]  TR_SPLIT      = 2'h2;
	localparam logic [1:0]  TR_SEPREM     = 2'h3;

	typedef enum logic [6:0] {
		F_IDLE    = 7'h01,
		F_RUNIN   = 7'h02,
		F_START   = 7'h04,
		F_CONTENT = 7'h08,
		F_STOP    = 7'h10,
		F_LRC     = 7'h20,
		F_DONE    = 7'h40
	} mdt_frame_t;

	typedef enum logic [3:0] {
		PH_IDLE  = 4'h1,
		PH_LEAD  = 4'h2,
		PH_LOW   = 4'h4,
		PH_TRAIL = 4'h8
	} mdt_phase_t;

endpackage : mdt_pkg

// file: verilog/mdt_transmitter.sv
/*
 * Magstripe track clock/data transmitter: frames nibbles as ISO2 or raw
 * digits and drives the open-collector clock and data lines.
 * Assumes the nibble source and settings run on clk; pins are resolved
 * outside from the *_oe outputs (high = pull line low).
 */
// Behaviour
// - Idle: clock and data released high
// - Bit clock is a low pulse
// - Data inverted: one drives low
// - Default cell: three 330 us thirds
// - Phase durations programmable by setting
// - Digit: four bits LSB first, parity
// - Decimal content holds digits 0..9, plus separator thirteen in codes 01 and 11
// - Format bit zero selects ISO2 frames
// - Translation field picks hex nibble conversion
// - Code 00 drops nibbles ten to fifteen
// - Code 01 replaces hex nibble by separator
// - Separator is digit thirteen
// - Code 10 sends two decimal digits each
// - Code 11 sends separator then value-ten
// - Sixteen zero bits before and after
// - Start sentinel eleven follows the run-in
// - Stop sentinel fifteen follows the content
// - LRC: XOR of start and content
// - Format bit one sends nibbles unmodified
// - Raw frames carry content digits only
`timescale 1ns/100ps

module mdt_transmitter #(
	parameter int unsigned PHASE_DEF = mdt_pkg::PHASE_CYCLES
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic [7:0]                  dataclock_setting_tag,
	input  wire logic                        timing_custom,
	input  wire logic [mdt_pkg::TIMER_W-1:0] lead_cycles,
	input  wire logic [mdt_pkg::TIMER_W-1:0] low_cycles,
	input  wire logic [mdt_pkg::TIMER_W-1:0] trail_cycles,
	input  wire logic                        in_valid,
	input  wire logic [3:0]                  in_nibble,
	input  wire logic                        in_last,
	output logic                             in_ack,
	output logic                             busy,
	output logic                             clock_o,
	output logic                             clock_oe,
	output logic                             data_o,
	output logic                             data_oe
);
	import mdt_pkg::*;

	function automatic logic [4:0] mdt_digit(input logic [3:0] v);
		return {~(^v), v};
	endfunction : mdt_digit

	mdt_frame_t           fr;
	mdt_frame_t           next_fr;
	mdt_phase_t           ph;
	logic [15:0]          shreg;
	logic [4:0]           cnt_bits;
	logic [TIMER_W-1:0]   ph_cnt;
	logic [TIMER_W-1:0]   dur_lead;
	logic [TIMER_W-1:0]   dur_low;
	logic [TIMER_W-1:0]   dur_trail;
	logic                 fmt_raw;
	logic [1:0]           trans;
	logic [3:0]           lrc;
	logic                 pend_valid;
	logic [3:0]           pend_dig;
	logic                 pend_last;
	logic                 lrc_sent;

	wire                  empty      = (cnt_bits == 5'h00) && (ph == PH_IDLE);
	wire                  take       = (fr == F_CONTENT) && empty && !pend_valid && in_valid && !in_ack;
	wire                  hex_nib    = in_nibble > DIG_MAX_DEC;
	wire [3:0]            nib_rem    = hex_nib ? 4'(in_nibble - DIG_TEN) : in_nibble;
	wire                  tr_drop    = !fmt_raw && (trans == TR_DROP);
	wire                  tr_sep     = !fmt_raw && (trans == TR_SEP);
	wire                  tr_split   = !fmt_raw && (trans == TR_SPLIT);
	wire                  tr_seprem  = !fmt_raw && (trans == TR_SEPREM);

	// Raw format passes the nibble through untouched
	wire [3:0]            first_val  = tr_split ? {3'h0, hex_nib} :
	                                   ((tr_sep || tr_seprem) && hex_nib) ? DIG_SEP :
	                                   in_nibble;
	wire                  first_keep = !(tr_drop && hex_nib);
	wire                  need_pend  = tr_split || (tr_seprem && hex_nib);

	wire                  ld_runin   = ((fr == F_RUNIN) || (fr == F_LRC && lrc_sent)) && empty;
	wire                  ld_start   = (fr == F_START) && empty;
	wire                  ld_pend    = (fr == F_CONTENT) && empty && pend_valid;
	wire                  ld_take    = take && first_keep;
	wire                  ld_stop    = (fr == F_STOP) && empty;
	wire                  ld_lrc     = (fr == F_LRC) && !lrc_sent && empty;
	wire                  load       = ld_runin || ld_start || ld_pend || ld_take || ld_stop || ld_lrc;
	wire [3:0]            load_val   = ld_start ? DIG_START :
	                                   ld_stop  ? DIG_STOP :
	                                   ld_lrc   ? lrc :
	                                   ld_pend  ? pend_dig : first_val;
	wire [15:0]           load_word  = ld_runin ? 16'h0000 : {11'h000, mdt_digit(load_val)};
	wire [4:0]            load_bits  = ld_runin ? RUN_BITS : DIGIT_BITS;
	wire                  content_end = (ld_pend && pend_last) || (take && !need_pend && in_last);

	wire [TIMER_W-1:0]    dur_cur    = (ph == PH_LEAD) ? dur_lead : (ph == PH_LOW) ? dur_low : dur_trail;
	wire [TIMER_W-1:0]    ph_cnt_inc = ph_cnt + 17'h00001;
	wire                  ph_end     = (ph != PH_IDLE) && (ph_cnt_inc >= dur_cur);

	// Frame sequencing; the trailing run-out reuses the run-in load in F_LRC
	always_comb begin
		next_fr = fr;
		case (fr)
			F_IDLE:    if (in_valid) next_fr = dataclock_setting_tag[SET_RAW_BIT] ? F_CONTENT : F_RUNIN;
			F_RUNIN:   if (empty) next_fr = F_START;
			F_START:   if (empty) next_fr = F_CONTENT;
			F_CONTENT: if (content_end) next_fr = fmt_raw ? F_DONE : F_STOP;
			F_STOP:    if (empty) next_fr = F_LRC;
			F_LRC:     if (ld_runin) next_fr = F_DONE;
			F_DONE:    if (empty) next_fr = F_IDLE;
			default:   next_fr = F_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fr   <= F_IDLE;
			busy <= 1'b0;
		end else begin
			fr   <= next_fr;
			busy <= next_fr != F_IDLE;
		end
	end

	// Setting is captured once per frame so a change mid-frame cannot tear it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fmt_raw   <= 1'b0;
			trans     <= TR_DROP;
			dur_lead  <= TIMER_W'(PHASE_CYCLES);
			dur_low   <= TIMER_W'(PHASE_CYCLES);
			dur_trail <= TIMER_W'(PHASE_CYCLES);
		end else if (fr == F_IDLE && in_valid) begin
			fmt_raw   <= dataclock_setting_tag[SET_RAW_BIT];
			trans     <= dataclock_setting_tag[SET_TRANS_LSB +: 2];
			dur_lead  <= timing_custom ? lead_cycles  : TIMER_W'(PHASE_DEF);
			dur_low   <= timing_custom ? low_cycles   : TIMER_W'(PHASE_DEF);
			dur_trail <= timing_custom ? trail_cycles : TIMER_W'(PHASE_DEF);
		end
	end

	// Content handshake, pending second digit and check digit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_ack     <= 1'b0;
			pend_valid <= 1'b0;
			pend_dig   <= 4'h0;
			pend_last  <= 1'b0;
			lrc        <= 4'h0;
			lrc_sent   <= 1'b0;
		end else begin
			in_ack <= take;
			if (take && need_pend) begin
				pend_valid <= 1'b1;
				pend_dig   <= nib_rem;
				pend_last  <= in_last;
			end else if (ld_pend) begin
				pend_valid <= 1'b0;
			end
			if (ld_start)
				lrc <= DIG_START;
			else if (ld_pend || ld_take)
				lrc <= lrc ^ load_val;
			if (fr == F_IDLE)
				lrc_sent <= 1'b0;
			else if (ld_lrc)
				lrc_sent <= 1'b1;
		end
	end

	// Shift register: LSB goes out first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg    <= 16'h0000;
			cnt_bits <= 5'h00;
		end else if (load) begin
			shreg    <= load_word;
			cnt_bits <= load_bits;
		end else if (ph == PH_TRAIL && ph_end) begin
			shreg    <= {1'b0, shreg[15:1]};
			cnt_bits <= 5'(cnt_bits - 5'h01);
		end
	end

	// Bit cell: lead (high), low pulse, trail (high)
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ph       <= PH_IDLE;
			ph_cnt   <= '0;
			clock_oe <= 1'b0;
			data_oe  <= 1'b0;
			clock_o  <= 1'b0;
			data_o   <= 1'b0;
		end else begin
			clock_o <= 1'b0;
			data_o  <= 1'b0;
			ph_cnt  <= (ph == PH_IDLE || ph_end) ? '0 : ph_cnt_inc;
			case (ph)
				PH_IDLE: if (cnt_bits != 5'h00) begin
					ph      <= PH_LEAD;
					data_oe <= shreg[0];
				end
				PH_LEAD: if (ph_end) begin
					ph       <= PH_LOW;
					clock_oe <= 1'b1;
				end
				PH_LOW: if (ph_end) begin
					ph       <= PH_TRAIL;
					clock_oe <= 1'b0;
				end
				PH_TRAIL: if (ph_end) begin
					if (cnt_bits > 5'h01) begin
						ph      <= PH_LEAD;
						data_oe <= shreg[1];
					end else begin
						ph      <= PH_IDLE;
						data_oe <= 1'b0;
					end
				end
				default: begin
					ph       <= PH_IDLE;
					clock_oe <= 1'b0;
					data_oe  <= 1'b0;
				end
			endcase
		end
	end

	// Helper: length of the last low phase, for the timing check
	logic [TIMER_W-1:0] low_len;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			low_len <= '0;
		else
			low_len <= clock_oe ? TIMER_W'(low_len + 17'h00001) : '0;
	end

	property p_idle_released;
		@(posedge clk) disable iff (!reset_n)
		(fr == F_IDLE && $past(fr) == F_IDLE) |-> (!clock_oe && !data_oe);
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("lines not released while idle");

	sequence s_lead_done;
		(ph == PH_LEAD && ph_end);
	endsequence
	sequence s_low_start;
		(ph == PH_LOW && clock_oe);
	endsequence
	property p_low_pulse;
		@(posedge clk) disable iff (!reset_n)
		s_lead_done |=> s_low_start;
	endproperty
	a_low_pulse: assert property (p_low_pulse) else $error("clock low pulse did not follow lead phase");

	property p_data_inverted;
		@(posedge clk) disable iff (!reset_n)
		clock_oe |-> (data_oe == shreg[0]);
	endproperty
	a_data_inverted: assert property (p_data_inverted) else $error("data line does not match bit");

	property p_low_length;
		@(posedge clk) disable iff (!reset_n)
		$fell(clock_oe) |-> (low_len == ((dur_low == '0) ? 17'h00001 : dur_low));
	endproperty
	a_low_length: assert property (p_low_length) else $error("low phase length wrong");

	property p_data_stable_low;
		@(posedge clk) disable iff (!reset_n)
		(clock_oe && $past(clock_oe)) |-> $stable(data_oe);
	endproperty
	a_data_stable_low: assert property (p_data_stable_low) else $error("data changed in low phase");

	property p_runin_zeros;
		@(posedge clk) disable iff (!reset_n)
		(fr == F_RUNIN && empty) |=> (cnt_bits == 5'h10 && shreg == 16'h0000) ##1 (fr == F_START);
	endproperty
	a_runin_zeros: assert property (p_runin_zeros) else $error("run-in not sixteen zeros");

	property p_start_sentinel;
		@(posedge clk) disable iff (!reset_n)
		(fr == F_START && empty) |=> (shreg[4:0] == 5'h0b && cnt_bits == 5'h05);
	endproperty
	a_start_sentinel: assert property (p_start_sentinel) else $error("start sentinel wrong");

	property p_stop_sentinel;
		@(posedge clk) disable iff (!reset_n)
		(fr == F_STOP && empty) |=> (shreg[4:0] == 5'h1f && fr == F_LRC);
	endproperty
	a_stop_sentinel: assert property (p_stop_sentinel) else $error("stop sentinel wrong");

	property p_odd_parity;
		@(posedge clk) disable iff (!reset_n)
		($past(empty) && cnt_bits == 5'h05) |-> (^shreg[4:0]);
	endproperty
	a_odd_parity: assert property (p_odd_parity) else $error("digit parity not odd");

	property p_separator;
		@(posedge clk) disable iff (!reset_n)
		(take && (tr_sep || tr_seprem) && hex_nib) |=> (shreg[3:0] == 4'hd);
	endproperty
	a_separator: assert property (p_separator) else $error("separator digit not thirteen");

	property p_drop;
		@(posedge clk) disable iff (!reset_n)
		(take && tr_drop && hex_nib) |=> (cnt_bits == 5'h00);
	endproperty
	a_drop: assert property (p_drop) else $error("hex nibble not dropped");

	property p_raw_no_stop;
		@(posedge clk) disable iff (!reset_n)
		(fmt_raw && fr == F_CONTENT && content_end) |=> (fr == F_DONE);
	endproperty
	a_raw_no_stop: assert property (p_raw_no_stop) else $error("raw frame got a postfix");

	property p_lrc_digit;
		@(posedge clk) disable iff (!reset_n)
		ld_lrc |=> (shreg[4:0] == mdt_digit($past(lrc)) && cnt_bits == DIGIT_BITS);
	endproperty
	a_lrc_digit: assert property (p_lrc_digit) else $error("check digit not loaded");

	// Tens digit goes first and the units digit must wait in the pending slot
	property p_split_tens;
		@(posedge clk) disable iff (!reset_n)
		(take && tr_split) |=> (shreg[3:0] == {3'h0, $past(hex_nib)} && pend_valid);
	endproperty
	a_split_tens: assert property (p_split_tens) else $error("split tens digit wrong");

	property p_raw_passthrough;
		@(posedge clk) disable iff (!reset_n)
		(take && fmt_raw) |=> (shreg[3:0] == $past(in_nibble));
	endproperty
	a_raw_passthrough: assert property (p_raw_passthrough) else $error("raw nibble altered");

endmodule : mdt_transmitter

// file: test/mdt_receiver.sv
/*
 * Behavioural access controller on the clock/data lines: collects the
 * received bits and measures the clock phases.
 * Assumes both lines are pulled up in the bench and sampled on clk.
 */
`timescale 1ns/100ps

module mdt_receiver (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic clock_line,
	input  wire logic data_line
);
	logic bits[$];
	int   low_len;
	int   high_len;
	int   n_glitch;
	int   run;
	logic clk_prev;
	logic data_prev;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_prev = 1'b1;
			data_prev = 1'b1;
			run = 0;
		end else begin
			if (clock_line !== clk_prev) begin
				if (clock_line) begin
					low_len = run;
				end else begin
					high_len = run;
					// Falling edge only, so a late data change cannot be caught
					bits.push_back(~data_line);
				end
				run = 0;
			end
			// Data moving inside the low phase would corrupt a level-sampling receiver
			if (!clock_line && !clk_prev && data_line !== data_prev) begin
				n_glitch++;
			end
			run++;
			clk_prev = clock_line;
			data_prev = data_line;
		end
	end
endmodule : mdt_receiver

// file: test/testbench.sv
/*
 * Self-checking bench of the clock/data transmitter: ISO2 frames in all
 * translation codes, a raw frame and the default bit timing.
 * Assumes pull-ups on both lines; PHASE_DEF shortened for simulation.
 */
`timescale 1ns/100ps

module testbench;
	import mdt_pkg::*;
	localparam int unsigned PHASE_SIM = 4;

	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  setting = 8'h00;
	logic        timing_custom = 1'b1;
	logic [16:0] lead = 17'h00005;
	logic [16:0] low = 17'h00006;
	logic [16:0] trail = 17'h00005;
	logic        in_valid = 1'b0;
	logic [3:0]  in_nibble = 4'h0;
	logic        in_last = 1'b0;
	logic        in_ack, busy, clock_o, clock_oe, data_o, data_oe;
	wire         clock_line = clock_oe ? clock_o : 1'b1;
	wire         data_line = data_oe ? data_o : 1'b1;
	int          n_mismatch, n_checks;
	logic        exp_bits[$];

	mdt_transmitter #(.PHASE_DEF(PHASE_SIM)) dut (.clk(clk), .reset_n(reset_n),
		.dataclock_setting_tag(setting), .timing_custom(timing_custom), .lead_cycles(lead),
		.low_cycles(low), .trail_cycles(trail), .in_valid(in_valid), .in_nibble(in_nibble),
		.in_last(in_last), .in_ack(in_ack), .busy(busy), .clock_o(clock_o), .clock_oe(clock_oe),
		.data_o(data_o), .data_oe(data_oe));
	mdt_receiver partner (.clk(clk), .reset_n(reset_n), .clock_line(clock_line), .data_line(data_line));

	always #2.5 clk = ~clk;

	task automatic check_val(input string what, input logic [16:0] exp, input logic [16:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic check_frame(input string what);
		int bad;
		bad = -1;
		n_checks++;
		foreach (exp_bits[i]) begin
			if (bad < 0 && (i >= partner.bits.size() || partner.bits[i] !== exp_bits[i])) begin
				bad = i;
			end
		end
		if (bad >= 0 || partner.bits.size() != exp_bits.size()) begin
			n_mismatch++;
			$display("unexpected %s: expected %0d bits, seen %0d, first bad bit %0d", what,
				exp_bits.size(), partner.bits.size(), bad);
		end
	endtask : check_frame

	task automatic push_digit(input logic [3:0] d);
		for (int i = 0; i < 4; i++) begin
			exp_bits.push_back(d[i]);
		end
		exp_bits.push_back(~^d);
	endtask : push_digit

	task automatic send_frame(input logic [7:0] set_val, input logic [3:0] nib[$]);
		int w;
		partner.bits.delete();
		@(negedge clk);
		setting = set_val;
		foreach (nib[i]) begin
			in_valid = 1'b1;
			in_nibble = nib[i];
			in_last = (i == nib.size() - 1);
			w = 0;
			do begin
				@(negedge clk);
				w++;
			end while (in_ack !== 1'b1 && w < 20000);
			check_val("nibble taken", 17'h1, 17'(in_ack));
		end
		in_valid = 1'b0;
		w = 0;
		while (busy !== 1'b0 && w < 20000) begin
			@(negedge clk);
			w++;
		end
		repeat (2) @(negedge clk);
		check_val("idle lines", 17'h0, {clock_oe, data_oe, busy});
		check_val("low phase glitches", 17'h0, 17'(partner.n_glitch));
	endtask : send_frame

	task automatic iso_frame(input logic [1:0] code, input logic [3:0] nib[$]);
		logic [3:0] lrc;
		exp_bits.delete();
		repeat (16) exp_bits.push_back(1'b0);
		push_digit(4'hb);
		lrc = 4'hb;
		foreach (nib[i]) begin
			case (code)
				2'h0: if (nib[i] <= 4'h9) begin push_digit(nib[i]); lrc ^= nib[i]; end
				2'h1: begin push_digit(nib[i] <= 4'h9 ? nib[i] : 4'hd); lrc ^= (nib[i] <= 4'h9 ? nib[i] : 4'hd); end
				2'h2: begin push_digit({3'h0, nib[i] > 4'h9}); push_digit(nib[i] > 4'h9 ? nib[i] - 4'ha : nib[i]);
					lrc ^= {3'h0, nib[i] > 4'h9} ^ (nib[i] > 4'h9 ? nib[i] - 4'ha : nib[i]); end
				default: begin if (nib[i] > 4'h9) begin push_digit(4'hd); lrc ^= 4'hd; end
					push_digit(nib[i] > 4'h9 ? nib[i] - 4'ha : nib[i]); lrc ^= (nib[i] > 4'h9 ? nib[i] - 4'ha : nib[i]); end
			endcase
		end
		push_digit(4'hf);
		push_digit(lrc);
		repeat (16) exp_bits.push_back(1'b0);
		send_frame({4'h0, code, 2'h0}, nib);
		check_frame("iso2 frame");
	endtask : iso_frame

	task automatic test_iso_codes();
		for (int c = 0; c < 4; c++) begin
			iso_frame(c[1:0], '{4'h7, 4'ha, 4'h1, 4'hf});
		end
		check_val("custom low phase", low, 17'(partner.low_len));
		check_val("custom high gap", lead + trail, 17'(partner.high_len));
		$display("test iso codes done");
	endtask : test_iso_codes

	task automatic test_raw();
		exp_bits.delete();
		push_digit(4'hf);
		push_digit(4'h0);
		push_digit(4'hc);
		// Translation bits set on purpose: raw must ignore them
		send_frame(8'h8c, '{4'hf, 4'h0, 4'hc});
		check_frame("raw frame");
		$display("test raw done");
	endtask : test_raw

	task automatic test_default_timing();
		timing_custom = 1'b0;
		iso_frame(2'h0, '{4'h3});
		check_val("default low phase", 17'(PHASE_SIM), 17'(partner.low_len));
		check_val("default high gap", 17'(2 * PHASE_SIM), 17'(partner.high_len));
		$display("test default timing done");
	endtask : test_default_timing

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		$display("unexpected run length: expected end of tests, seen watchdog expiry");
		finish_test();
	end

	initial begin
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check_val("lines after reset", 17'h0, {clock_oe, data_oe, busy});
		test_iso_codes();
		test_raw();
		test_default_timing();
		finish_test();
	end
endmodule : testbench
